// ### core/gsp_pkg.sv
// constants, register map and carrier types for the port and serial-pin block
// assumes a word-addressed Avalon-MM slave: the address port carries the register index
package gsp_pkg;
  // register indices as they stand on the slave's address port
  localparam logic [31:0] GSP_IDX_CTRL = 32'hFFFFFF76;
  localparam logic [31:0] GSP_IDX_DATA = 32'hFFFFFF78;
  localparam logic [31:0] GSP_IDX_SPORT = 32'hFFFFFF7C;
  localparam logic [31:0] GSP_IDX_SHARE = 32'hFFFFFF7E;
  localparam int GSP_NBITS = 8;
  localparam int GSP_NSYNC = 11;
  localparam logic [15:0] GSP_CTRL_RST = 16'h0000;
  localparam logic [1:0] GSP_SPORT_CTL_RST = 2'h0;
  // serial-pin register fields
  localparam int GSP_SP_RXD = 0;
  localparam int GSP_SP_TXOE = 1;
  localparam int GSP_SP_SCK = 2;
  localparam int GSP_SP_SCKOE = 3;
  // synchroniser vector positions above the eight port bits
  localparam int GSP_SY_SCK = 8;
  localparam int GSP_SY_TXD = 9;
  localparam int GSP_SY_RXD = 10;
  localparam logic [1:0] GSP_RSP_OK = 2'h0;
  localparam logic [1:0] GSP_RSP_ERR = 2'h2;
  // cycles for the pin synchroniser to settle before straps are taken
  localparam logic [1:0] GSP_STRAP_SETTLE = 2'h3;
  typedef struct packed {
    logic bus_sel;
    logic sync_mode;
    logic cks_hi;
    logic cks_lo;
    logic rx_on;
    logic tx_on;
  } gsp_share_t;
  localparam gsp_share_t GSP_SHARE_RST = 6'h00;
  typedef struct packed {
    logic out;
    logic oe;
  } gsp_drive_t;
  typedef enum logic [0:0] {
    GSP_ST_STRAP = 1'b0,
    GSP_ST_RUN = 1'b1
  } gsp_state_t;
endpackage

// ### core/gsp_port.sv
// 8-bit general-purpose port plus the serial-pin port register
// assumes pins are resolved outside from out/oe pairs; serial unit sits beside it
`timescale 1ns/1ps
`default_nettype none
module gsp_port
  import gsp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic [1:0] response,
  output logic waitrequest,
  input wire logic [7:0] port_pin_in,
  output logic [7:0] port_pin_out,
  output logic [7:0] port_pin_oe,
  output logic [7:0] port_pullup_en,
  input wire logic [7:0] bus_data_out,
  input wire logic bus_data_oe,
  output logic [7:0] bus_data_in,
  input wire logic sck_pin_in,
  output logic sck_pin_out,
  output logic sck_pin_oe,
  input wire logic txd_pin_in,
  output logic txd_pin_out,
  output logic txd_pin_oe,
  input wire logic rxd_pin_in,
  input wire logic sci_sck_out,
  input wire logic sci_sck_oe,
  input wire logic sci_txd_out,
  output logic sci_sck_in,
  output logic sci_rxd_in,
  output gsp_share_t serial_settings,
  output logic [2:0] mode_strap_inputs,
  output logic strap_phase
);

  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic [15:0] ctrl_q;
  logic [7:0] latch_q;
  logic [1:0] sp_ctl_q;
  logic sp_sck_dt_q;
  logic sp_txd_dt_q;
  gsp_share_t share_q;
  gsp_state_t state_q;
  logic [1:0] settle_q;
  logic [2:0] strap_q;
  logic [GSP_NSYNC-1:0] raw;
  logic [GSP_NSYNC-1:0] s1_q;
  logic [GSP_NSYNC-1:0] s2_q;
  logic [GSP_NSYNC-1:0] s3_q;
  logic [GSP_NSYNC-1:0] filt_q;
  logic [7:0] pull_d;
  logic [7:0] dir_d;
  logic [7:0] pout_d;
  logic [7:0] poe_d;
  gsp_drive_t sck_d;
  gsp_drive_t txd_d;
  gsp_drive_t sck_q;
  gsp_drive_t txd_q;
  logic [7:0] pout_q;
  logic [7:0] poe_q;
  logic hit_ctrl;
  logic hit_data;
  logic hit_sport;
  logic hit_share;
  logic hit_any;
  logic wr_go;
  logic sck_serial;
  logic txd_serial;

  // bus slave: one wait state, answer on the second edge of a request
  assign waitrequest = (read | write) & ~ack_q;
  assign readdata = rdata_q;
  assign response = resp_q;
  assign hit_ctrl = (address == GSP_IDX_CTRL);
  assign hit_data = (address == GSP_IDX_DATA);
  assign hit_sport = (address == GSP_IDX_SPORT);
  assign hit_share = (address == GSP_IDX_SHARE);
  assign hit_any = hit_ctrl | hit_data | hit_sport | hit_share;
  assign wr_go = write & ack_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // read data captured on the first edge, held while the master samples it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 32'h00000000;
      resp_q <= GSP_RSP_OK;
    end else if ((read | write) & ~ack_q) begin
      resp_q <= hit_any ? GSP_RSP_OK : GSP_RSP_ERR;
      rdata_q <= 32'h00000000;
      if (read) begin
        if (hit_ctrl) begin
          rdata_q[15:0] <= ctrl_q;
        end
        if (hit_data) begin
          rdata_q[7:0] <= filt_q[7:0];
        end
        if (hit_sport) begin
          // upper nibble stays zero
          rdata_q[GSP_SP_SCKOE] <= sp_ctl_q[1];
          rdata_q[GSP_SP_SCK] <= filt_q[GSP_SY_SCK];
          rdata_q[GSP_SP_TXOE] <= sp_ctl_q[0];
          rdata_q[GSP_SP_RXD] <= filt_q[GSP_SY_RXD];
        end
        if (hit_share) begin
          rdata_q[5:0] <= share_q;
        end
      end
    end
  end

  // control register: only power-on reset clears it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= GSP_CTRL_RST;
    end else if (wr_go & hit_ctrl) begin
      if (byteenable[0]) begin
        ctrl_q[7:0] <= writedata[7:0];
      end
      if (byteenable[1]) begin
        ctrl_q[15:8] <= writedata[15:8];
      end
    end
  end

  // data latch has no reset at all
  always_ff @(posedge sys_clk) begin
    if (wr_go & hit_data & byteenable[0]) begin
      latch_q <= writedata[7:0];
    end
  end

  // serial-pin enables cleared at power-on; data bits keep no reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_ctl_q <= GSP_SPORT_CTL_RST;
    end else if (wr_go & hit_sport & byteenable[0]) begin
      sp_ctl_q <= {writedata[GSP_SP_SCKOE], writedata[GSP_SP_TXOE]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (wr_go & hit_sport & byteenable[0]) begin
      sp_sck_dt_q <= writedata[GSP_SP_SCK];
      sp_txd_dt_q <= writedata[GSP_SP_RXD];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      share_q <= GSP_SHARE_RST;
    end else if (wr_go & hit_share & byteenable[0]) begin
      share_q <= writedata[5:0];
    end
  end
  assign serial_settings = share_q;

  // three-stage synchroniser; a change counts once stages two and three agree
  assign raw = {rxd_pin_in, txd_pin_in, sck_pin_in, port_pin_in};
  genvar gi;
  generate
    for (gi = 0; gi < GSP_NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            filt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate
  assign bus_data_in = filt_q[7:0];
  assign sci_sck_in = filt_q[GSP_SY_SCK];
  assign sci_rxd_in = filt_q[GSP_SY_RXD];

  // strap phase: serial pins stay inputs until software programs them
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= GSP_ST_STRAP;
      settle_q <= 2'h0;
      strap_q <= 3'h0;
    end else begin
      unique case (state_q)
        GSP_ST_STRAP: begin
          if (settle_q != GSP_STRAP_SETTLE) begin
            settle_q <= settle_q + 2'h1;
          end else begin
            strap_q <= {filt_q[GSP_SY_RXD], filt_q[GSP_SY_TXD], filt_q[GSP_SY_SCK]};
            if (wr_go & (hit_share | hit_sport)) begin
              state_q <= GSP_ST_RUN;
            end
          end
        end
        GSP_ST_RUN: begin
          state_q <= GSP_ST_RUN;
        end
      endcase
    end
  end
  assign mode_strap_inputs = strap_q;
  assign strap_phase = (state_q == GSP_ST_STRAP);

  // general port: direction and pull-up per bit
  generate
    for (gi = 0; gi < GSP_NBITS; gi++) begin : g_bit
      assign dir_d[gi] = ctrl_q[2*gi];
      // pull-up follows its bit whatever the direction
      assign pull_d[gi] = ~ctrl_q[2*gi+1];
    end
  endgenerate
  assign port_pullup_en = pull_d;

  // bus mode hands the pins to the external data bus
  always_comb begin
    if (share_q.bus_sel) begin
      pout_d = bus_data_out;
      poe_d = {8{bus_data_oe}};
    end else begin
      pout_d = latch_q;
      poe_d = dir_d;
    end
  end

  // serial use of each shared pin
  assign sck_serial = share_q.cks_hi | share_q.cks_lo | share_q.sync_mode;
  assign txd_serial = share_q.tx_on;

  always_comb begin
    sck_d = 2'h0;
    txd_d = 2'h0;
    if (state_q == GSP_ST_RUN) begin
      if (sck_serial) begin
        sck_d = {sci_sck_out, sci_sck_oe};
      end else if (sp_ctl_q[1]) begin
        sck_d = {sp_sck_dt_q, 1'b1};
      end
      if (txd_serial) begin
        txd_d = {sci_txd_out, 1'b1};
      end else if (sp_ctl_q[0]) begin
        txd_d = {sp_txd_dt_q, 1'b1};
      end
    end
  end

  // pin drives registered so outputs never glitch on decode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pout_q <= 8'h00;
      poe_q <= 8'h00;
      sck_q <= 2'h0;
      txd_q <= 2'h0;
    end else begin
      pout_q <= pout_d;
      poe_q <= poe_d;
      sck_q <= sck_d;
      txd_q <= txd_d;
    end
  end
  assign port_pin_out = pout_q;
  assign port_pin_oe = poe_q;
  assign sck_pin_out = sck_q.out;
  assign sck_pin_oe = sck_q.oe;
  assign txd_pin_out = txd_q.out;
  assign txd_pin_oe = txd_q.oe;

  AST_DIR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !share_q.bus_sel |=> port_pin_oe == $past(dir_d))
    else $error("port output enable does not follow direction bits");

  AST_PULL: assert property (@(posedge sys_clk) disable iff (!reset_n)
    port_pullup_en == ~{ctrl_q[15], ctrl_q[13], ctrl_q[11], ctrl_q[9],
                        ctrl_q[7], ctrl_q[5], ctrl_q[3], ctrl_q[1]})
    else $error("pull-up does not follow its control bit");

  AST_CTRL_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(wr_go && hit_ctrl) |=> $stable(ctrl_q))
    else $error("control register changed without a write");

  AST_DATA_OUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!share_q.bus_sel && $stable(latch_q)) |=> port_pin_out == $past(latch_q))
    else $error("output pins do not show the data latch");

  AST_DATA_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (read && hit_data && !ack_q) |=> readdata[7:0] == $past(filt_q[7:0]))
    else $error("data read does not return pin levels");

  AST_RSVD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (read && hit_sport && ack_q) |-> readdata[7:4] == 4'h0)
    else $error("serial register upper bits not zero");

  AST_SCK: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == GSP_ST_RUN && !sck_serial && sp_ctl_q[1])
      |=> sck_pin_oe && sck_pin_out == $past(sp_sck_dt_q))
    else $error("clock pin not driven from port bit");

  AST_SCK_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (read && hit_sport && !ack_q) |=> readdata[GSP_SP_SCK] == $past(filt_q[GSP_SY_SCK]))
    else $error("clock pin level not returned");

  AST_TXD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!txd_serial && !sp_ctl_q[0]) |=> !txd_pin_oe)
    else $error("transmit pin driven with output disabled");

  AST_RXD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (read && hit_sport && !ack_q) ##1 ack_q |-> readdata[GSP_SP_RXD] == $past(filt_q[GSP_SY_RXD]))
    else $error("receive pin level not returned");

  AST_STRAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    strap_phase |=> !sck_pin_oe && !txd_pin_oe)
    else $error("serial pins driven during strap phase");

  AST_BUS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    share_q.bus_sel |=> port_pin_oe == {8{$past(bus_data_oe)}})
    else $error("bus mode does not hand pins to the bus");

  AST_SERIAL_WINS: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_q == GSP_ST_RUN && txd_serial) |=> txd_pin_oe && txd_pin_out == $past(sci_txd_out))
    else $error("serial unit does not own the transmit pin");

  AST_WAIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait state");

endmodule
`default_nettype wire

// ### tb/gsp_board.sv
// board model for the port and serial pins: external drivers, pull-ups, floating lines
// assumes the bench picks the external levels and enables; design wins where it drives
`timescale 1ns/1ps
`default_nettype none
module gsp_board (
  input wire logic sys_clk,
  input wire logic [7:0] port_pin_out,
  input wire logic [7:0] port_pin_oe,
  input wire logic [7:0] port_pullup_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic txd_out,
  input wire logic txd_oe,
  input wire logic ext_sck,
  input wire logic ext_txd,
  input wire logic ext_rxd,
  output logic [7:0] port_pin_in,
  output logic sck_pin_in,
  output logic txd_pin_in,
  output logic rxd_pin_in
);
  logic [7:0] float_q;
  // undriven, unpulled line: a changing pattern, never a settled guess
  always @(posedge sys_clk) float_q <= (float_q === 8'h5A) ? 8'hA5 : 8'h5A;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (port_pin_oe[i]) port_pin_in[i] = port_pin_out[i];
      else if (ext_en[i]) port_pin_in[i] = ext_val[i];
      else if (port_pullup_en[i]) port_pin_in[i] = 1'b1;
      else port_pin_in[i] = float_q[i];
    end
  end
  assign sck_pin_in = sck_oe ? sck_out : ext_sck;
  assign txd_pin_in = txd_oe ? txd_out : ext_txd;
  assign rxd_pin_in = ext_rxd;
endmodule
`default_nettype wire

// ### tb/tb_gpio_and_serial_pin_port.sv
// self-checking bench for the port block, random data with corner cases
// assumes gsp_port with one wait state on its Avalon slave and the board model beside it
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_and_serial_pin_port;
  import gsp_pkg::*;
  logic sys_clk = 0, reset_n = 0, read = 0, write = 0, bus_data_oe = 0;
  logic [31:0] address = 0, writedata = 0, readdata, rd;
  logic [3:0] byteenable = 0;
  logic [1:0] response, rs;
  logic waitrequest, sck_pin_in, sck_pin_out, sck_pin_oe, txd_pin_in, txd_pin_out, txd_pin_oe;
  logic rxd_pin_in, sci_sck_out = 0, sci_sck_oe = 0, sci_txd_out = 0, strap_phase;
  logic [7:0] port_pin_in, port_pin_out, port_pin_oe, port_pullup_en, bus_data_out = 0;
  logic [7:0] ext_val = 0, ext_en = 0, lat, d, p;
  logic ext_sck = 0, ext_txd = 0, ext_rxd = 0;
  logic [2:0] mode_strap_inputs;
  logic [7:0] bus_data_in;
  logic sci_sck_in, sci_rxd_in;
  gsp_share_t serial_settings;
  int seed = 87, n_errors = 0, checked = 0;
  always #50 sys_clk = ~sys_clk;
  gsp_port dut (.sys_clk(sys_clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .response(response), .waitrequest(waitrequest), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .port_pullup_en(port_pullup_en),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .bus_data_in(bus_data_in),
    .sck_pin_in(sck_pin_in), .sck_pin_out(sck_pin_out), .sck_pin_oe(sck_pin_oe),
    .txd_pin_in(txd_pin_in), .txd_pin_out(txd_pin_out), .txd_pin_oe(txd_pin_oe),
    .rxd_pin_in(rxd_pin_in), .sci_sck_out(sci_sck_out), .sci_sck_oe(sci_sck_oe),
    .sci_txd_out(sci_txd_out), .sci_sck_in(sci_sck_in), .sci_rxd_in(sci_rxd_in),
    .serial_settings(serial_settings),
    .mode_strap_inputs(mode_strap_inputs), .strap_phase(strap_phase));
  gsp_board board (.sys_clk(sys_clk), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
    .port_pullup_en(port_pullup_en), .ext_val(ext_val), .ext_en(ext_en),
    .sck_out(sck_pin_out), .sck_oe(sck_pin_oe), .txd_out(txd_pin_out), .txd_oe(txd_pin_oe),
    .ext_sck(ext_sck), .ext_txd(ext_txd), .ext_rxd(ext_rxd), .port_pin_in(port_pin_in),
    .sck_pin_in(sck_pin_in), .txd_pin_in(txd_pin_in), .rxd_pin_in(rxd_pin_in));
  task automatic results;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ck_reg(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t register read %h expected %h", $time, g, e);
    end
  endtask
  task automatic ck_pin(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t pin value %h expected %h", $time, g, e);
    end
  endtask
  // one transfer; request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v,
      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= v;
    byteenable <= be;
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      n_errors++;
      results();
    end
    rd = readdata;
    rs = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // pin synchroniser plus output register need a few edges
  task automatic settle;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  function automatic logic [15:0] mk(input logic [7:0] dir, input logic [7:0] pu);
    for (int i = 0; i < 8; i++) mk[2*i +: 2] = {pu[i], dir[i]};
  endfunction
  initial begin
    ext_sck = $random(seed);
    ext_txd = $random(seed);
    ext_rxd = $random(seed);
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    settle();
    ck_pin(strap_phase, 8'h01);
    ck_pin({sck_pin_oe, txd_pin_oe}, 8'h00);
    ck_pin(port_pin_oe, 8'h00);
    ck_pin(port_pullup_en, 8'hFF);
    bus(0, GSP_IDX_CTRL, 0, 4'hF);
    ck_reg(rd, 32'h0);
    ck_pin(rs, GSP_RSP_OK);
    bus(0, GSP_IDX_SPORT, 0, 4'hF);
    ck_reg(rd & 32'hFA, 32'h0);
    bus(1, GSP_IDX_SHARE, 32'h0, 4'hF); // serial unit off first
    settle();
    ck_pin(strap_phase, 8'h00);
    ck_pin(mode_strap_inputs, {ext_rxd, ext_txd, ext_sck});
    bus(0, 32'hFFFFFF70, 0, 4'hF);
    ck_reg(rd, 32'h0); // unmapped place
    ck_pin(rs, GSP_RSP_ERR); // unmapped place
    for (int k = 0; k < 10; k++) begin
      lat = $random(seed);
      d = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : $random(seed);
      p = d | $random(seed);
      bus(1, GSP_IDX_DATA, {24'h0, lat}, 4'hF); // latch before outputs
      ext_val <= $random(seed);
      ext_en <= ~d;
      bus(1, GSP_IDX_CTRL, {16'h0, mk(d, p)}, 4'h3); // no pull-up on outputs
      settle();
      ck_pin(port_pin_oe, d);
      ck_pin(port_pullup_en, ~p);
      ck_pin(port_pin_out & d, lat & d);
      bus(0, GSP_IDX_DATA, 0, 4'hF);
      ck_reg(rd & 32'hFF, {24'h0, (lat & d) | (ext_val & ~d)});
      bus(0, GSP_IDX_CTRL, 0, 4'hF);
      ck_reg(rd & 32'hFFFF, {16'h0, mk(d, p)});
    end
    bus(1, GSP_IDX_CTRL, 32'h5555, 4'h3);
    settle();
    ck_pin(port_pullup_en & port_pin_oe, 8'hFF);
    bus(1, GSP_IDX_CTRL, 32'hFFFF, 4'h1);
    bus(0, GSP_IDX_CTRL, 0, 4'hF);
    ck_reg(rd & 32'hFFFF, 32'h55FF);
    bus(1, GSP_IDX_CTRL, 32'h0, 4'h3);
    ext_en <= 8'h00;
    settle();
    bus(0, GSP_IDX_DATA, 0, 4'hF);
    ck_reg(rd & 32'hFF, 32'hFF);
    ck_pin(bus_data_in, 8'hFF);
    for (int i = 0; i < 16; i++) begin
      bus(1, GSP_IDX_SPORT, i, 4'hF); // upper nibble written as zero
      ext_sck <= $random(seed);
      ext_rxd <= $random(seed);
      settle();
      ck_pin({sck_pin_oe, sck_pin_out & sck_pin_oe}, {i[3], i[3] & i[2]});
      ck_pin({txd_pin_oe, txd_pin_out & txd_pin_oe}, {i[1], i[1] & i[0]});
      bus(0, GSP_IDX_SPORT, 0, 4'hF);
      ck_reg(rd, {28'h0, i[3], i[3] ? i[2] : ext_sck, i[1], ext_rxd});
      ck_pin({sci_sck_in, sci_rxd_in}, {i[3] ? i[2] : ext_sck, ext_rxd});
    end
    bus(1, GSP_IDX_SPORT, 32'hA, 4'hF);
    sci_txd_out <= 1'b1;
    sci_sck_out <= 1'b1;
    sci_sck_oe <= 1'b1;
    bus(1, GSP_IDX_SHARE, 32'h05, 4'hF);
    settle();
    ck_pin({sck_pin_oe, sck_pin_out, txd_pin_oe, txd_pin_out}, 8'h0F);
    ck_pin(serial_settings, 8'h05);
    bus(0, GSP_IDX_SHARE, 0, 4'hF);
    ck_reg(rd, 32'h05);
    @(posedge sys_clk);
    sci_sck_oe <= 1'b0;
    // each clock-source or mode bit alone must take the clock pin from the port
    for (int j = 0; j < 3; j++) begin
      bus(1, GSP_IDX_SHARE, (32'h4 << j) | 32'h2, 4'hF);
      settle();
      ck_pin({sck_pin_oe, txd_pin_oe, txd_pin_out}, 8'h02);
      ck_pin(serial_settings, (8'h4 << j) | 8'h02);
    end
    @(posedge sys_clk);
    bus_data_out <= $random(seed);
    bus_data_oe <= 1'b1;
    bus(1, GSP_IDX_SHARE, 32'h20, 4'hF);
    settle();
    ck_pin(port_pin_oe, 8'hFF);
    ck_pin(port_pin_out, bus_data_out);
    ck_pin(bus_data_in, bus_data_out);
    results();
  end
endmodule
`default_nettype wire
